// File: mss_pkg.sv
package mss_pkg;
    localparam int          MSS_SCENES         = 8;
    localparam int          MSS_BLOCKS         = 8;
    localparam int          MSS_LVL_W          = 8;
    localparam int          MSS_PRESET_W       = 7;
    localparam logic [6:0]  MSS_CC_SELECT_RST  = 7'h22;
    localparam logic [6:0]  MSS_CC_UP_RST      = 7'h7B;
    localparam logic [6:0]  MSS_CC_DOWN_RST    = 7'h7C;
    localparam logic [6:0]  MSS_STEP_MIN       = 7'h40;
    localparam logic [7:0]  MSS_LVL_RST        = 8'h80;
    localparam logic [3:0]  MSS_OFS_CTRL       = 4'h0;
    localparam logic [3:0]  MSS_OFS_CCNUM      = 4'h1;
    localparam logic [3:0]  MSS_OFS_STATUS     = 4'h2;
    localparam logic [3:0]  MSS_OFS_MAP        = 4'h3;
    localparam logic [3:0]  MSS_OFS_EDIT       = 4'h4;
    localparam logic [3:0]  MSS_OFS_CMD        = 4'h5;
    localparam logic [3:0]  MSS_OFS_SCENE      = 4'h6;
    localparam logic [31:0] MSS_UNMAPPED       = 32'hDEADBEEF;
    localparam int          MSS_CTRL_CUSTOM    = 0;
    localparam int          MSS_CTRL_REVERT    = 1;
    localparam int          MSS_CTRL_SKIPREP   = 2;
    localparam int          MSS_CMD_SAVE       = 0;
    localparam int          MSS_CMD_LOAD       = 1;
    localparam int          MSS_CMD_KNOB       = 2;
    typedef enum logic [1:0] {MSS_EV_NONE, MSS_EV_CC, MSS_EV_PC} mss_ev_e;
endpackage

// File: mss_msg_if.sv
`timescale 1ns/1ns
interface mss_msg_if;
    import mss_pkg::*;
    logic       valid;
    mss_ev_e    kind;
    logic [6:0] num;
    logic [6:0] val;
    modport src (output valid, output kind, output num, output val);
    modport dst (input valid, input kind, input num, input val);
endinterface

// File: mss_midi_rx.sv
`timescale 1ns/1ns
module mss_midi_rx
    import mss_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  reset,
    input  wire logic  enable,
    input  wire logic  byte_valid,
    input  wire logic [7:0] byte_data,
    input  wire logic [3:0] channel,
    mss_msg_if.src     msg
);
    typedef struct packed {
        logic       want_data;
        logic       have_first;
        mss_ev_e    kind;
        logic [6:0] first;
        logic       valid;
        logic [6:0] num;
        logic [6:0] val;
    } mss_rx_s;
    mss_rx_s st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        if (byte_valid) begin
            if (byte_data[7]) begin
                st_nxt.have_first = 1'b0;
                st_nxt.want_data = (byte_data[3:0] == channel) &&
                    (byte_data[7:4] == 4'hB || byte_data[7:4] == 4'hC);
                st_nxt.kind = (byte_data[7:4] == 4'hC) ? MSS_EV_PC
                                                      : MSS_EV_CC;
            end else if (st_r.want_data) begin
                if (st_r.kind == MSS_EV_PC) begin
                    st_nxt.valid = 1'b1;
                    st_nxt.num   = byte_data[6:0];
                    st_nxt.val   = 7'h00;
                end else if (!st_r.have_first) begin
                    st_nxt.have_first = 1'b1;
                    st_nxt.first      = byte_data[6:0];
                end else begin
                    st_nxt.have_first = 1'b0;
                    st_nxt.valid      = 1'b1;
                    st_nxt.num        = st_r.first;
                    st_nxt.val        = byte_data[6:0];
                end
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else if (enable) begin
            st_r <= st_nxt;
        end
    end

    assign msg.valid = st_r.valid & enable;
    assign msg.kind  = st_r.kind;
    assign msg.num   = st_r.num;
    assign msg.val   = st_r.val;

    a_pc_one_byte: assert property (@(posedge clock) disable iff (reset)
        (enable && byte_valid && !byte_data[7] && st_r.want_data &&
         st_r.kind == MSS_EV_PC) |=> st_r.valid)
        else $error("program change not emitted");
endmodule // mss_midi_rx

// File: midi_scene_selector.sv
`timescale 1ns/1ns
// Operation
// R1 - direct select uses configurable controller number, 34 after reset
// R2 - direct select picks scene value mod eight plus one
// R3 - step up and step down controllers configurable, 123 and 124 default
// R4 - step controllers act only for values 64 to 127
// R5 - custom mode maps program change to preset and scene
// R6 - repeated program for active preset skipped when option on; in custom mode the code still applies the mapped scene
// R7 - program map edits take effect immediately, no save
// R8 - revert off keeps scene edits until preset load or reload
// R9 - revert on discards unsaved edits on scene change
// R10 - save stores all scenes; knob selection keeps edits until save
// R11 - input-muted bypass lets effect tails continue
// R12 - scene output level scales all output including tails
// R13 - every scene change is reported to the foot controller
// R14 - eight scenes each hold bypass, xy, main and loop levels
// R15 - new preset engages every block in scenes two to eight
// R16 - unmatched controller numbers leave scene unchanged
module midi_scene_selector
    import mss_pkg::*;
#(
    parameter int NB = MSS_BLOCKS
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        enable,
    input  wire logic        midi_byte_valid,
    input  wire logic [7:0]  midi_byte,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic      [2:0]  scene,
    output logic      [6:0]  preset,
    output logic             scene_changed,
    output logic      [NB-1:0] bypass,
    output logic      [NB-1:0] silence_effect_input,
    output logic      [NB-1:0] xy_sel,
    output logic      [7:0]  main_level,
    output logic      [7:0]  loop_level
);
    localparam int SW = 2 * NB + 2 * MSS_LVL_W;
    typedef logic [SW-1:0] mss_snap_t;
    typedef struct packed {
        logic [2:0]              ctrl;
        logic [3:0]              chan;
        logic [6:0]              cc_select;
        logic [6:0]              step_up_controller_number;
        logic [6:0]              step_down_controller_number;
        logic [NB-1:0]           mute_in;
        logic [127:0][9:0]       map;
        logic [MSS_SCENES-1:0][SW-1:0] live;
        logic [MSS_SCENES-1:0][SW-1:0] saved;
        logic [2:0]              scene;
        logic [6:0]              preset;
        logic                    changed;
        logic [31:0]             rdata;
        logic                    ack;
    } mss_st_s;
    mss_st_s st_r, st_nxt;
    logic       midi_byte_valid_s1, midi_byte_valid_s2;
    logic [7:0] midi_byte_s1, midi_byte_s2;
    mss_msg_if msg ();

    mss_midi_rx u_rx (
        .clock      (clock),
        .reset      (reset),
        .enable     (enable),
        .byte_valid (midi_byte_valid_s2),
        .byte_data  (midi_byte_s2),
        .channel    (st_r.chan),
        .msg        (msg)
    );

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            midi_byte_valid_s1 <= 1'b0;
            midi_byte_valid_s2 <= 1'b0;
            midi_byte_s1       <= 8'h00;
            midi_byte_s2       <= 8'h00;
        end else if (enable) begin
            midi_byte_valid_s1 <= midi_byte_valid;
            midi_byte_valid_s2 <= midi_byte_valid_s1;
            midi_byte_s1       <= midi_byte;
            midi_byte_s2       <= midi_byte_s1;
        end
    end

    function automatic mss_snap_t new_snap(input logic [2:0] idx);
        mss_snap_t s;
        s = '0;
        s[MSS_LVL_W +: MSS_LVL_W]   = MSS_LVL_RST;
        s[MSS_LVL_W-1:0]            = MSS_LVL_RST;
        if (idx != 3'h0) begin
            s[SW-1 -: NB] = '0; // engaged, bypass clear [R15]
        end else begin
            s[SW-1 -: NB] = '1;
        end
        return s;
    endfunction

    logic       sel_valid;
    logic [2:0] sel_scene;
    logic [6:0] sel_preset;
    logic       is_write, is_read;

    always_comb begin
        st_nxt     = st_r;
        sel_valid  = 1'b0;
        sel_scene  = st_r.scene;
        sel_preset = st_r.preset;
        is_write   = write && st_r.ack; // lands as wait drops
        is_read    = read && !st_r.ack;
        st_nxt.changed = 1'b0;
        st_nxt.ack     = (read || write) && !st_r.ack;
        if (msg.valid && msg.kind == MSS_EV_CC) begin
            if (msg.num == st_r.cc_select) begin // [R1]
                sel_valid = 1'b1;
                sel_scene = msg.val[2:0]; // mod eight, shown plus one [R2]
            end else if (msg.num == st_r.step_up_controller_number) begin
                sel_valid = msg.val >= MSS_STEP_MIN; // [R3] [R4]
                sel_scene = st_r.scene + 3'h1;
            end else if (msg.num == st_r.step_down_controller_number) begin
                sel_valid = msg.val >= MSS_STEP_MIN; // [R3] [R4]
                sel_scene = st_r.scene - 3'h1;
            end
            // other controller numbers fall through idle [R16]
        end else if (msg.valid && msg.kind == MSS_EV_PC) begin
            sel_valid  = 1'b1;
            sel_preset = msg.num;
            if (st_r.ctrl[MSS_CTRL_CUSTOM]) begin // [R5] [R7]
                sel_preset = st_r.map[msg.num][9:3];
                sel_scene  = st_r.map[msg.num][2:0];
            end
            if (sel_preset != st_r.preset ||
                !st_r.ctrl[MSS_CTRL_SKIPREP]) begin // [R6]
                st_nxt.live   = st_r.saved; // preset (re)load [R8]
                st_nxt.preset = sel_preset;
                st_nxt.changed = 1'b1;
                if (!st_r.ctrl[MSS_CTRL_CUSTOM]) begin
                    sel_scene = 3'h0;
                end
            end
        end
        if (is_write && address == MSS_OFS_CMD &&
            writedata[MSS_CMD_KNOB]) begin
            sel_valid = 1'b1; // knob never reverts [R10]
            sel_scene = writedata[10:8];
        end
        if (sel_valid && sel_scene != st_r.scene) begin
            if (st_r.ctrl[MSS_CTRL_REVERT] &&
                !(is_write && address == MSS_OFS_CMD)) begin // [R9]
                st_nxt.live[st_r.scene] = st_r.saved[st_r.scene];
            end
            st_nxt.scene   = sel_scene;
            st_nxt.changed = 1'b1; // [R13]
        end
        if (is_write) begin
            case (address)
                MSS_OFS_CTRL: begin
                    st_nxt.ctrl    = writedata[2:0];
                    st_nxt.chan    = writedata[7:4];
                    st_nxt.mute_in = writedata[8 +: NB];
                end
                MSS_OFS_CCNUM: begin
                    st_nxt.cc_select                   = writedata[6:0];
                    st_nxt.step_up_controller_number   = writedata[14:8];
                    st_nxt.step_down_controller_number = writedata[22:16];
                end
                MSS_OFS_MAP: begin
                    st_nxt.map[writedata[22:16]] = writedata[9:0]; // [R7]
                end
                MSS_OFS_EDIT: begin
                    st_nxt.live[st_r.scene] = writedata[SW-1:0];
                end
                MSS_OFS_CMD: begin
                    if (writedata[MSS_CMD_SAVE]) begin
                        st_nxt.saved = st_nxt.live; // all scenes [R10]
                    end
                    if (writedata[MSS_CMD_LOAD]) begin
                        for (int i = 0; i < MSS_SCENES; i++) begin
                            st_nxt.saved[i] = new_snap(3'(i)); // [R14]
                            st_nxt.live[i]  = new_snap(3'(i));
                        end
                        st_nxt.scene   = 3'h0;
                        st_nxt.changed = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (is_read) begin
            case (address)
                MSS_OFS_CTRL:   st_nxt.rdata = 32'({st_r.mute_in, st_r.chan,
                                    1'b0, st_r.ctrl});
                MSS_OFS_CCNUM:  st_nxt.rdata = 32'({
                                    1'b0, st_r.step_down_controller_number,
                                    1'b0, st_r.step_up_controller_number,
                                    1'b0, st_r.cc_select});
                MSS_OFS_STATUS: st_nxt.rdata = 32'({st_r.preset, 1'b0,
                                    st_r.scene});
                MSS_OFS_EDIT:   st_nxt.rdata = 32'(st_r.live[st_r.scene]);
                MSS_OFS_SCENE:  st_nxt.rdata = 32'(st_r.saved[st_r.scene]);
                default:        st_nxt.rdata = MSS_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.cc_select                   <= MSS_CC_SELECT_RST;
            st_r.step_up_controller_number   <= MSS_CC_UP_RST;
            st_r.step_down_controller_number <= MSS_CC_DOWN_RST;
            for (int i = 0; i < MSS_SCENES; i++) begin
                st_r.live[i]  <= new_snap(3'(i));
                st_r.saved[i] <= new_snap(3'(i));
            end
        end else if (enable) begin
            st_r <= st_nxt;
        end
    end

    mss_snap_t cur;
    assign cur = st_r.live[st_r.scene];
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            readdata             <= 32'h00000000;
            waitrequest          <= 1'b1;
            scene                <= 3'h0;
            preset               <= 7'h00;
            scene_changed        <= 1'b0;
            bypass               <= '0;
            silence_effect_input <= '0;
            xy_sel               <= '0;
            main_level           <= 8'h00;
            loop_level           <= 8'h00;
        end else if (enable) begin
            readdata      <= st_nxt.rdata;
            waitrequest   <= !st_nxt.ack;
            scene         <= st_r.scene;
            preset        <= st_r.preset;
            scene_changed <= st_r.changed; // [R13]
            bypass        <= cur[SW-1 -: NB];
            // input-muted bypass keeps tails ringing [R11]
            silence_effect_input <= cur[SW-1 -: NB] & st_r.mute_in;
            xy_sel        <= cur[2*MSS_LVL_W +: NB];
            main_level    <= cur[MSS_LVL_W +: MSS_LVL_W]; // [R12]
            loop_level    <= cur[MSS_LVL_W-1:0];
        end
    end

    a_direct_select: assert property (@(posedge clock) disable iff (reset)
        (enable && msg.valid && msg.kind == MSS_EV_CC &&
         msg.num == st_r.cc_select) |=> st_r.scene == $past(msg.val[2:0]))
        else $error("direct select wrong scene"); // [R2]
    a_step_low_ignored: assert property (@(posedge clock) disable iff (reset)
        (enable && msg.valid && msg.kind == MSS_EV_CC && !write &&
         msg.num == st_r.step_up_controller_number &&
         msg.num != st_r.cc_select && msg.val < MSS_STEP_MIN)
        |=> $stable(st_r.scene))
        else $error("low step value moved scene"); // [R4]
    a_change_reported: assert property (@(posedge clock) disable iff (reset)
        (enable && st_r.scene != $past(st_r.scene)) |-> st_r.changed)
        else $error("scene change not flagged"); // [R13]
    a_change_output: assert property (@(posedge clock) disable iff (reset)
        (enable && st_r.changed) |=> scene_changed)
        else $error("scene change not reported"); // [R13]
    a_wait_release: assert property (@(posedge clock) disable iff (reset)
        (enable && (read || write) && waitrequest) |=> !waitrequest)
        else $error("waitrequest held too long");
    a_reset_cc_default: assert property (@(posedge clock)
        $fell(reset) |-> st_r.cc_select == MSS_CC_SELECT_RST)
        else $error("select controller default wrong"); // [R1]
    a_level_follows: assert property (@(posedge clock) disable iff (reset)
        enable && $past(enable) && !$past(reset) |-> main_level ==
            $past(cur[MSS_LVL_W +: MSS_LVL_W]))
        else $error("main level not from scene"); // [R12]
    a_tail_mute: assert property (@(posedge clock) disable iff (reset)
        enable && $past(enable) |-> (silence_effect_input & ~bypass) == '0)
        else $error("input mute without bypass"); // [R11]
    c_direct: cover property (@(posedge clock) msg.valid &&
        msg.kind == MSS_EV_CC && msg.num == st_r.cc_select);
    c_step_up: cover property (@(posedge clock) msg.valid &&
        msg.num == st_r.step_up_controller_number && msg.val[6]);
    c_pc_custom: cover property (@(posedge clock) msg.valid &&
        msg.kind == MSS_EV_PC && st_r.ctrl[MSS_CTRL_CUSTOM]);
endmodule // midi_scene_selector

// File: mss_midi_src.sv
`timescale 1ns/1ns
// midi sender model; the data line shows the inverted byte four cycles after the strobe drops
module mss_midi_src (
    input  wire logic       clock,
    output logic            midi_byte_valid,
    output logic [7:0]      midi_byte
);
    initial begin
        midi_byte_valid = 1'b0;
        midi_byte       = 8'hFF;
    end
    // one-cycle strobe, byte held through the receiver sync
    task automatic send_byte(input logic [7:0] b);
        @(posedge clock);
        midi_byte_valid <= 1'b1;
        midi_byte       <= b;
        @(posedge clock);
        midi_byte_valid <= 1'b0;
        repeat (4) @(posedge clock);
        midi_byte       <= ~b;
    endtask
    task automatic send_cc(input logic [6:0] n, input logic [6:0] v);
        send_byte(8'hB0);
        send_byte({1'b0, n});
        send_byte({1'b0, v});
    endtask
    task automatic send_pc(input logic [6:0] p);
        send_byte(8'hC0);
        send_byte({1'b0, p});
    endtask
endmodule // mss_midi_src

// File: midi_scene_selector_tb.sv
`timescale 1ns/1ns
module midi_scene_selector_tb;
    import mss_pkg::*;
    logic        clock;
    logic        reset;
    logic        enable;
    logic        midi_byte_valid;
    logic [7:0]  midi_byte;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [2:0]  scene;
    logic [6:0]  preset;
    logic        scene_changed;
    logic [7:0]  bypass;
    logic [7:0]  silence_effect_input;
    logic [7:0]  xy_sel;
    logic [7:0]  main_level;
    logic [7:0]  loop_level;
    int          failures;
    int          compares;
    int          cycles;
    int          chg_cnt;
    int          chg_exp;
    logic [6:0]  dv [8] = '{7'h01, 7'h0A, 7'h7F, 7'h40,
                            7'h2D, 7'h00, 7'h47, 7'h16};
    logic [6:0]  sn [6] = '{7'h7B, 7'h7B, 7'h7B, 7'h7C, 7'h7C, 7'h23};
    logic [6:0]  sv [6] = '{7'h40, 7'h7F, 7'h3F, 7'h40, 7'h00, 7'h03};
    logic [2:0]  se [6] = '{3'h7, 3'h0, 3'h0, 3'h7, 3'h7, 3'h7};
    int          sd [6] = '{1, 1, 0, 1, 0, 0};

    midi_scene_selector #(.NB(8)) uut (
        .clock                (clock),
        .reset                (reset),
        .enable               (enable),
        .midi_byte_valid      (midi_byte_valid),
        .midi_byte            (midi_byte),
        .address              (address),
        .read                 (read),
        .write                (write),
        .writedata            (writedata),
        .readdata             (readdata),
        .waitrequest          (waitrequest),
        .scene                (scene),
        .preset               (preset),
        .scene_changed        (scene_changed),
        .bypass               (bypass),
        .silence_effect_input (silence_effect_input),
        .xy_sel               (xy_sel),
        .main_level           (main_level),
        .loop_level           (loop_level)
    );
    mss_midi_src src (
        .clock           (clock),
        .midi_byte_valid (midi_byte_valid),
        .midi_byte       (midi_byte)
    );

    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check_out(input string nm, input logic [31:0] e,
                             input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        address   <= a;
        writedata <= d;
        write     <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        write     <= 1'b0;
    endtask
    // read a register and compare it with the expected word
    task automatic check_reg(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        @(posedge clock);
        address <= a;
        read    <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        d = readdata;
        read    <= 1'b0;
        compares++;
        if (d !== e) begin
            failures++;
            $display("ERROR reg %0d expected %h seen %h", a, e, d);
        end
    endtask
    // let a message land, then check scene and change pulses
    task automatic settle(input logic [2:0] es, input int d);
        repeat (12) @(posedge clock);
        chg_exp += d;
        check_out("scene", {29'h0, es}, {29'h0, scene});
        check_out("change count", chg_exp, chg_cnt);
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        if (scene_changed === 1'b1) chg_cnt <= chg_cnt + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            $display("timeout reached");
            failures++;
            print_verdict();
        end
    end

    initial begin
        reset = 1'b1;
        enable = 1'b1;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        failures = 0;
        compares = 0;
        cycles = 0;
        chg_cnt = 0;
        chg_exp = 0;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        check_reg(MSS_OFS_CCNUM, 32'h007C7B22);
        check_reg(MSS_OFS_STATUS, 32'h00000000);
        check_reg(4'h7, MSS_UNMAPPED);
        check_out("main level", 32'h80, {24'h0, main_level});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            src.send_cc(MSS_CC_SELECT_RST, dv[i]);
            settle(dv[i][2:0], 1);
        end
        $display("test direct done");
        for (int i = 0; i < 6; i++) begin
            src.send_cc(sn[i], sv[i]);
            settle(se[i], sd[i]);
        end
        $display("test step done");
        bus_wr(MSS_OFS_CMD, 32'h00000002);
        for (int i = 0; i < 8; i++) begin
            src.send_cc(MSS_CC_SELECT_RST, 7'(i));
            repeat (12) @(posedge clock);
            check_out("bypass", (i == 0) ? 32'hFF : 32'h0,
                      32'(bypass));
        end
        chg_exp += 8; // load pulse plus seven direct selects
        $display("test new preset done");
        src.send_cc(MSS_CC_SELECT_RST, 7'h01);
        settle(3'h1, 1);
        bus_wr(MSS_OFS_EDIT, 32'h0F5A4020);
        repeat (2) @(posedge clock);
        check_out("bypass", 32'h0F, {24'h0, bypass});
        check_out("xy", 32'h5A, {24'h0, xy_sel});
        check_out("loop level", 32'h20, {24'h0, loop_level});
        src.send_cc(MSS_CC_SELECT_RST, 7'h02);
        settle(3'h2, 1);
        src.send_cc(MSS_CC_SELECT_RST, 7'h01);
        settle(3'h1, 1);
        check_out("main level", 32'h40, {24'h0, main_level});
        $display("test sticky done");
        bus_wr(MSS_OFS_CTRL, 32'h00003C02);
        bus_wr(MSS_OFS_CMD, 32'h00000001);
        check_reg(MSS_OFS_SCENE, 32'h0F5A4020);
        check_out("mute", 32'h0C, {24'h0, silence_effect_input});
        bus_wr(MSS_OFS_EDIT, 32'h0F003020);
        src.send_cc(MSS_CC_SELECT_RST, 7'h02);
        settle(3'h2, 1);
        src.send_cc(MSS_CC_SELECT_RST, 7'h01);
        settle(3'h1, 1);
        check_out("main level", 32'h40, {24'h0, main_level});
        bus_wr(MSS_OFS_EDIT, 32'h0F005020);
        bus_wr(MSS_OFS_CMD, 32'h00000204);
        settle(3'h2, 1);
        bus_wr(MSS_OFS_CMD, 32'h00000104);
        settle(3'h1, 1);
        check_out("main level", 32'h50, {24'h0, main_level});
        $display("test revert done");
        bus_wr(MSS_OFS_CTRL, 32'h00000005);
        bus_wr(MSS_OFS_MAP, 32'h0005001C);
        src.send_pc(7'h05);
        settle(3'h4, 1);
        check_out("preset", 32'h3, {25'h0, preset});
        bus_wr(MSS_OFS_MAP, 32'h0005001E);
        src.send_pc(7'h05);
        settle(3'h6, 1);
        check_reg(MSS_OFS_STATUS, 32'h00000036);
        $display("test program map done");
        bus_wr(MSS_OFS_CCNUM, 32'h00121110);
        check_reg(MSS_OFS_CCNUM, 32'h00121110);
        src.send_cc(7'h22, 7'h00);
        settle(3'h6, 0);
        src.send_cc(7'h10, 7'h03);
        settle(3'h3, 1);
        src.send_cc(7'h11, 7'h40);
        settle(3'h4, 1);
        src.send_cc(7'h7B, 7'h40);
        settle(3'h4, 0);
        src.send_cc(7'h12, 7'h64);
        settle(3'h3, 1);
        $display("test reconfigure done");
        enable <= 1'b0;
        src.send_cc(7'h10, 7'h00);
        settle(3'h3, 0);
        enable <= 1'b1;
        src.send_cc(7'h10, 7'h05);
        settle(3'h5, 1);
        $display("test enable done");
        print_verdict();
    end
endmodule // midi_scene_selector_tb
